/* File: ebip_buf2.sv */
// ebip_buf2.sv: two-entry read data buffer with valid and ready on both sides
`timescale 1ns/10ps
module ebip_buf2 (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input ebip_pkg::ebip_rsp_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output ebip_pkg::ebip_rsp_t out_data
);
	import ebip_pkg::*;

	ebip_buf_t buf_ff;
	ebip_buf_t nxt_buf;
	logic pop;
	logic push;

	assign in_ready = ~buf_ff.tail_vld;
	assign out_valid = buf_ff.head_vld;
	assign out_data = buf_ff.head;
	assign pop = buf_ff.head_vld & out_ready;
	assign push = in_valid & ~buf_ff.tail_vld;

	// head always holds the oldest word; tail only fills while head waits
	always_comb begin
		nxt_buf = buf_ff;
		if (pop) begin
			nxt_buf.head = buf_ff.tail;
			nxt_buf.head_vld = buf_ff.tail_vld;
			nxt_buf.tail_vld = 1'b0;
		end
		if (push) begin
			if (!nxt_buf.head_vld) begin
				nxt_buf.head = in_data;
				nxt_buf.head_vld = 1'b1;
			end else begin
				nxt_buf.tail = in_data;
				nxt_buf.tail_vld = 1'b1;
			end
		end
		if (sys_rst) begin
			nxt_buf.head_vld = 1'b0;
			nxt_buf.tail_vld = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		buf_ff <= nxt_buf;
	end
endmodule : ebip_buf2

/* File: ebip_map.svh */
// ebip_map.svh: named constants of the external bus pin interface
`ifndef EBIP_MAP_SVH
`define EBIP_MAP_SVH
`define EBIP_ST_IDLE 2'h0
`define EBIP_ST_ADDR 2'h1
`define EBIP_ST_COL 2'h3
`define EBIP_ST_XFER 2'h2
`define EBIP_BOOT_8 2'h0
`define EBIP_BOOT_16 2'h1
`define EBIP_BOOT_32 2'h2
`define EBIP_BOOT_WAIT0 2'h0
`define EBIP_BOOT_STEP 2'h1
`define EBIP_BOOT_SETTLE 2'h2
`define EBIP_FIRST_DRAM_BANK 3'h4
`define EBIP_DRAM_CFG_W 4
`define EBIP_DMA_CH3 2'h3
`define EBIP_WAIT_ZERO 4'h0
`define EBIP_WAIT_STEP 4'h1
`define EBIP_ADDR_W 24
`define EBIP_DATA_W 32
`define EBIP_LANES 4
`endif

/* File: ebip_mem_model.sv */
// ebip_mem_model.sv: memory bank model answering on the data and fault pins
`timescale 1ns/10ps
module ebip_mem_model (
	input wire logic core_clk,
	input wire logic [0:3] sram_select_bank_n,
	input wire logic [4:7] bank_select_or_row_strobe_n,
	input wire logic [0:3] column_strobe_lane_n,
	input wire logic [5:0] addr_lo_out,
	input wire logic [9:0] addr_mid_out,
	input wire logic [7:0] addr_hi_out,
	input wire logic [0:31] data_out,
	input wire logic read_write_out,
	input wire logic fault_en,
	output logic [0:31] data_in,
	output logic bus_fault_in_n
);
	logic sel;
	logic [0:31] wr_word = 32'h0;
	logic [0:3] lanes_seen = 4'hf;
	assign sel = {sram_select_bank_n, bank_select_or_row_strobe_n} != 8'hff;
	initial begin
		data_in = 32'h0;
		bus_fault_in_n = 1'h1;
	end
	always @(posedge core_clk) begin
		// a selected bank answers a read with a word built from the address pins; otherwise the data pins toggle
		data_in <= (sel && read_write_out) ? {8'ha5, addr_lo_out, addr_mid_out, addr_hi_out} : ~data_in;
		bus_fault_in_n <= !(sel && fault_en);
		if (sel && !read_write_out)
			wr_word <= data_out;
		if (column_strobe_lane_n != 4'hf)
			lanes_seen <= column_strobe_lane_n;
	end
endmodule : ebip_mem_model

/* File: ebip_pkg.sv */
// ebip_pkg.sv: types of the external bus pin interface
`include "ebip_map.svh"
package ebip_pkg;
	typedef enum logic [1:0] {
		st_idle = `EBIP_ST_IDLE,
		st_addr = `EBIP_ST_ADDR,
		st_col = `EBIP_ST_COL,
		st_xfer = `EBIP_ST_XFER
	} ebip_fsm_t;

	typedef enum logic [1:0] {
		boot_8 = `EBIP_BOOT_8,
		boot_16 = `EBIP_BOOT_16,
		boot_32 = `EBIP_BOOT_32
	} ebip_boot_t;

	// addr[23:18] is pin A6..A11, addr[17:8] A12..A21, addr[7:0] A22..A29
	typedef struct packed {
		logic [`EBIP_ADDR_W-1:0] addr;
		logic [`EBIP_DATA_W-1:0] wdata;
		logic [0:`EBIP_LANES-1] be;
		logic write;
		logic [2:0] bank;
		logic [3:0] waits;
		logic dma;
		logic [1:0] dma_ch;
		logic last;
	} ebip_req_t;

	typedef struct packed {
		logic [`EBIP_DATA_W-1:0] rdata;
		logic fault;
	} ebip_rsp_t;

	typedef struct packed {
		logic [`EBIP_DATA_W-1:0] data;
		logic [5:0] addr_lo;
		logic [7:0] addr_hi;
		logic fault_n;
		logic irq_n;
		logic boot;
		logic takeover;
		logic [0:3] dma_req_n;
		logic [0:3] eot_n;
		logic oe_n;
		logic rw;
	} ebip_pin_in_t;

	typedef struct packed {
		logic [5:0] bank_sel;
		logic [7:0] page;
		logic [1:0] size;
		logic dram_req;
		logic read;
	} ebip_ext_t;

	typedef struct packed {
		ebip_pin_in_t sy1;
		ebip_pin_in_t sy2;
		ebip_fsm_t fsm;
		logic grant;
		ebip_req_t req;
		logic [3:0] wait_cnt;
		logic boot_rst_smp;
		logic boot_done;
		logic [1:0] boot_wait;
		ebip_boot_t boot_width;
		logic irq_low_seen;
		logic irq_pulse;
		logic sys_err;
		logic fault_pulse;
		ebip_ext_t ext;
		logic ext_ack;
		logic page_cross;
	} ebip_state_t;

	typedef struct packed {
		ebip_rsp_t head;
		ebip_rsp_t tail;
		logic head_vld;
		logic tail_vld;
	} ebip_buf_t;
endpackage : ebip_pkg

/* File: ebip_top.sv */
// ebip_top.sv: pin-level external bus interface for memory banks, dma and external masters
`timescale 1ns/10ps
`include "ebip_map.svh"
//
// Function
// - A6-A11 drive as master, else bank-select inputs
// - A12-A21 driven only while bus master
// - A22-A29 drive as master, else page inputs
// - column select low for row, high column
// - boot width sampled in and after reset
// - bus fault sampled only in final cycle
// - regain request while granted and work pending
// - shared pin is dma strobe when ungranted
// - dma strobe marks each dma transfer completion
// - four column strobes, one per byte lane
// - banks 0-3 have dedicated sram selects
// - banks 4-7 select or reversed row strobe
// - 32-bit data bus, bit 0 most significant
// - dma ack per channel; ch3 external data ack
// - dram read/write enables for both masters
// - end/count pin role per channel bit
// - system error held until syndrome cleared
// - grant high when bus given, low regained
// - sram read enable, else size bit 1
module ebip_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	output logic req_ready,
	input ebip_pkg::ebip_req_t req,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output ebip_pkg::ebip_rsp_t rsp,
	output logic bus_fault,
	input wire logic [`EBIP_DRAM_CFG_W-1:0] bank_is_dram,
	input wire logic [0:3] end_or_count_role_bit,
	output logic [0:3] dma_req,
	output logic [0:3] dma_end_request,
	input wire logic machine_check_detect,
	input wire logic syndrome_clear,
	output logic sys_error,
	output logic critical_irq,
	output ebip_pkg::ebip_boot_t boot_width,
	output logic boot_width_valid,
	output ebip_pkg::ebip_ext_t ext_master,
	output logic ext_page_cross,
	input wire logic [5:0] addr_lo_in,
	output logic [5:0] addr_lo_out,
	output logic addr_lo_oe,
	output logic [9:0] addr_mid_out,
	output logic addr_mid_oe,
	input wire logic [7:0] addr_hi_in,
	output logic [7:0] addr_hi_out,
	output logic addr_hi_oe,
	input wire logic [0:`EBIP_DATA_W-1] data_in,
	output logic [0:`EBIP_DATA_W-1] data_out,
	output logic data_oe,
	input wire logic read_write_in,
	output logic read_write_out,
	output logic read_write_oe,
	output logic addr_mux_column_select,
	input wire logic boot_width_select,
	input wire logic bus_fault_in_n,
	output logic bus_regain_request_dma_transfer_strobe,
	output logic [0:`EBIP_LANES-1] column_strobe_lane_n,
	input wire logic critical_irq_in_n,
	output logic [0:3] sram_select_bank_n,
	output logic [4:7] bank_select_or_row_strobe_n,
	output logic [0:3] dma_ack_ch_n,
	input wire logic [0:3] dma_req_ch_n,
	output logic dram_read_enable_n,
	output logic dram_write_strobe_n,
	input wire logic [0:3] dma_end_or_count_ch_n_in,
	output logic [0:3] dma_end_or_count_ch_n_out,
	output logic [0:3] dma_end_or_count_ch_n_oe,
	input wire logic sram_read_enable_n_in,
	output logic sram_read_enable_n_out,
	output logic sram_read_enable_n_oe,
	output logic bus_grant_out,
	input wire logic bus_takeover_request
);
	import ebip_pkg::*;

	ebip_state_t st_ff;
	ebip_state_t nxt_st;
	ebip_pin_in_t pin_now;
	ebip_rsp_t push_data;
	logic push_valid;
	logic buf_in_ready;
	logic final_cycle;
	logic cur_dram;
	logic dma_xfer;
	logic ext_dram;

	function automatic logic ebip_is_dram(input logic [2:0] bank, input logic [`EBIP_DRAM_CFG_W-1:0] cfg);
		return (bank >= `EBIP_FIRST_DRAM_BANK) && cfg[bank[1:0]];
	endfunction : ebip_is_dram

	function automatic logic ebip_bank_hit(input ebip_state_t s, input logic [2:0] idx);
		return (s.fsm != st_idle) && (s.req.bank == idx);
	endfunction : ebip_bank_hit

	// every pin input passes two flops before use
	always_comb begin
		pin_now.data = data_in;
		pin_now.addr_lo = addr_lo_in;
		pin_now.addr_hi = addr_hi_in;
		pin_now.fault_n = bus_fault_in_n;
		pin_now.irq_n = critical_irq_in_n;
		pin_now.boot = boot_width_select;
		pin_now.takeover = bus_takeover_request;
		pin_now.dma_req_n = dma_req_ch_n;
		pin_now.eot_n = dma_end_or_count_ch_n_in;
		pin_now.oe_n = sram_read_enable_n_in;
		pin_now.rw = read_write_in;
	end

	assign final_cycle = (st_ff.fsm == st_xfer) && (st_ff.wait_cnt == `EBIP_WAIT_ZERO);
	assign cur_dram = ebip_is_dram(st_ff.req.bank, bank_is_dram);
	assign dma_xfer = final_cycle && st_ff.req.dma;
	assign ext_dram = st_ff.grant && st_ff.ext.dram_req;
	assign push_valid = final_cycle && !st_ff.req.write;
	assign push_data.rdata = st_ff.sy2.data;
	assign push_data.fault = ~st_ff.sy2.fault_n;
	// a read is only accepted when the buffer can take its answer
	assign req_ready = (st_ff.fsm == st_idle) && !st_ff.grant && !st_ff.sy2.takeover
		&& (req.write || buf_in_ready);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sy1 = pin_now;
		nxt_st.sy2 = st_ff.sy1;
		nxt_st.irq_pulse = 1'b0;
		nxt_st.fault_pulse = 1'b0;
		nxt_st.page_cross = 1'b0;
		unique case (st_ff.fsm)
			st_idle: begin
				if (st_ff.grant) begin
					if (!st_ff.sy2.takeover) begin
						nxt_st.grant = 1'b0;
					end
				end else if (st_ff.sy2.takeover) begin
					nxt_st.grant = 1'b1;
				end else if (req_valid && req_ready) begin
					nxt_st.req = req;
					nxt_st.wait_cnt = req.waits;
					nxt_st.fsm = st_addr;
				end
			end
			st_addr: begin
				nxt_st.fsm = cur_dram ? st_col : st_xfer;
			end
			st_col: begin
				nxt_st.fsm = st_xfer;
			end
			st_xfer: begin
				if (final_cycle) begin
					nxt_st.fsm = st_idle;
					nxt_st.fault_pulse = ~st_ff.sy2.fault_n;
				end else begin
					nxt_st.wait_cnt = st_ff.wait_cnt - `EBIP_WAIT_STEP;
				end
			end
		endcase
		// external master view of the shared pins
		if (st_ff.grant) begin
			nxt_st.ext.bank_sel = st_ff.sy2.addr_lo;
			nxt_st.ext.page = st_ff.sy2.addr_hi;
			nxt_st.ext.size = {~st_ff.sy2.oe_n, ~st_ff.sy2.eot_n[`EBIP_DMA_CH3]};
			nxt_st.ext.dram_req = ~st_ff.sy2.dma_req_n[`EBIP_DMA_CH3];
			nxt_st.ext.read = st_ff.sy2.rw;
			nxt_st.page_cross = st_ff.ext_ack && (st_ff.ext.page != st_ff.sy2.addr_hi);
		end else begin
			nxt_st.ext.dram_req = 1'b0;
		end
		nxt_st.ext_ack = ext_dram;
		// critical interrupt needs a low phase followed by a high phase
		if (!st_ff.sy2.irq_n) begin
			nxt_st.irq_low_seen = 1'b1;
		end else if (st_ff.irq_low_seen) begin
			nxt_st.irq_low_seen = 1'b0;
			nxt_st.irq_pulse = 1'b1;
		end
		// detection wins over a clear in the same cycle
		if (machine_check_detect) begin
			nxt_st.sys_err = 1'b1;
		end else if (syndrome_clear) begin
			nxt_st.sys_err = 1'b0;
		end
		// boot width: one sample during reset, one once the synced pin shows the released level
		if (!st_ff.boot_done && (st_ff.boot_wait != `EBIP_BOOT_SETTLE)) begin
			nxt_st.boot_wait = st_ff.boot_wait + `EBIP_BOOT_STEP;
		end else if (!st_ff.boot_done) begin
			nxt_st.boot_done = 1'b1;
			if (st_ff.boot_rst_smp == st_ff.sy2.boot) begin
				nxt_st.boot_width = st_ff.sy2.boot ? boot_32 : boot_8;
			end else begin
				nxt_st.boot_width = boot_16;
			end
		end
		if (sys_rst) begin
			nxt_st.fsm = st_idle;
			nxt_st.grant = 1'b0;
			nxt_st.req = '0;
			nxt_st.wait_cnt = `EBIP_WAIT_ZERO;
			nxt_st.boot_rst_smp = st_ff.sy2.boot;
			nxt_st.boot_done = 1'b0;
			nxt_st.boot_wait = `EBIP_BOOT_WAIT0;
			nxt_st.boot_width = boot_8;
			nxt_st.irq_low_seen = 1'b0;
			nxt_st.irq_pulse = 1'b0;
			nxt_st.sys_err = 1'b0;
			nxt_st.fault_pulse = 1'b0;
			nxt_st.ext = '0;
			nxt_st.ext_ack = 1'b0;
			nxt_st.page_cross = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		st_ff <= nxt_st;
	end

	ebip_buf2 u_rsp_buf (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_valid(push_valid),
		.in_ready(buf_in_ready),
		.in_data(push_data),
		.out_valid(rsp_valid),
		.out_ready(rsp_ready),
		.out_data(rsp)
	);

	// core-side status
	assign bus_fault = st_ff.fault_pulse;
	assign sys_error = st_ff.sys_err;
	assign critical_irq = st_ff.irq_pulse;
	assign boot_width = st_ff.boot_width;
	assign boot_width_valid = st_ff.boot_done;
	assign ext_master = st_ff.ext;
	assign ext_page_cross = st_ff.page_cross;

	// address, data and direction pins, released while granted
	assign addr_lo_out = st_ff.req.addr[23:18];
	assign addr_lo_oe = !st_ff.grant;
	assign addr_mid_out = st_ff.req.addr[17:8];
	assign addr_mid_oe = !st_ff.grant;
	assign addr_hi_out = st_ff.req.addr[7:0];
	assign addr_hi_oe = !st_ff.grant;
	assign data_out = st_ff.req.wdata;
	assign data_oe = !st_ff.grant && st_ff.req.write && (st_ff.fsm == st_xfer);
	assign read_write_out = !st_ff.req.write;
	assign read_write_oe = !st_ff.grant;

	// dram row/column multiplexer select
	assign addr_mux_column_select = cur_dram && ((st_ff.fsm == st_col) || (st_ff.fsm == st_xfer));

	// shared pin: regain request while granted, dma strobe otherwise (active low)
	assign bus_regain_request_dma_transfer_strobe = st_ff.grant ? req_valid : !dma_xfer;

	// sram output enable, or size bit 1 while granted
	assign sram_read_enable_n_out = !(!cur_dram && !st_ff.req.write && (st_ff.fsm == st_xfer));
	assign sram_read_enable_n_oe = !st_ff.grant;

	// dram enables for own and external master accesses
	assign dram_read_enable_n = !((cur_dram && !st_ff.req.write && (st_ff.fsm == st_xfer))
		|| (ext_dram && st_ff.ext.read));
	assign dram_write_strobe_n = !((cur_dram && st_ff.req.write && (st_ff.fsm == st_xfer))
		|| (ext_dram && !st_ff.ext.read));

	assign bus_grant_out = st_ff.grant;

	// per-lane, per-bank and per-channel pins
	always_comb begin
		for (int i = 0; i < `EBIP_LANES; i++) begin
			column_strobe_lane_n[i] = !(cur_dram && st_ff.req.be[i]
				&& ((st_ff.fsm == st_col) || (st_ff.fsm == st_xfer)));
		end
		for (int i = 0; i < 4; i++) begin
			sram_select_bank_n[i] = !ebip_bank_hit(st_ff, 3'(i));
		end
		// pin of bank k is also row strobe 7-k, so the bank hit drives both roles
		for (int i = 4; i < 8; i++) begin
			bank_select_or_row_strobe_n[i] = !ebip_bank_hit(st_ff, 3'(i));
		end
		for (int i = 0; i < 4; i++) begin
			dma_ack_ch_n[i] = !((st_ff.fsm != st_idle) && st_ff.req.dma
				&& (st_ff.req.dma_ch == 2'(i)));
			dma_req[i] = !st_ff.sy2.dma_req_n[i];
			dma_end_request[i] = !end_or_count_role_bit[i] && !st_ff.sy2.eot_n[i];
			dma_end_or_count_ch_n_out[i] = !(dma_xfer && st_ff.req.last
				&& (st_ff.req.dma_ch == 2'(i)));
			dma_end_or_count_ch_n_oe[i] = end_or_count_role_bit[i];
		end
		// channel 3 pins change role while an external master owns the bus
		if (st_ff.grant) begin
			dma_ack_ch_n[`EBIP_DMA_CH3] = !st_ff.ext_ack;
			dma_req[`EBIP_DMA_CH3] = 1'b0;
			dma_end_request[`EBIP_DMA_CH3] = 1'b0;
			dma_end_or_count_ch_n_oe[`EBIP_DMA_CH3] = 1'b0;
		end
	end
endmodule : ebip_top

/* File: ebip_top_assertions.sv */
// ebip_top_assertions.sv: concurrent checks on the pins of the bus interface top
`timescale 1ns/10ps
module ebip_top_chk (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic bus_grant_out,
	input wire logic bus_takeover_request,
	input wire logic addr_lo_oe,
	input wire logic addr_mid_oe,
	input wire logic addr_hi_oe,
	input wire logic data_oe,
	input wire logic read_write_oe,
	input wire logic read_write_out,
	input wire logic bus_regain_request_dma_transfer_strobe,
	input wire logic addr_mux_column_select,
	input wire logic [0:3] column_strobe_lane_n,
	input wire logic [0:3] sram_select_bank_n,
	input wire logic [4:7] bank_select_or_row_strobe_n,
	input wire logic [0:3] dma_ack_ch_n,
	input wire logic dram_read_enable_n,
	input wire logic dram_write_strobe_n,
	input wire logic critical_irq_in_n,
	input wire logic critical_irq,
	input wire logic machine_check_detect,
	input wire logic syndrome_clear,
	input wire logic sys_error
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence irq_low_high;
		!critical_irq_in_n ##1 critical_irq_in_n;
	endsequence
	sequence dma_strobe_on;
		!bus_grant_out && !bus_regain_request_dma_transfer_strobe;
	endsequence
	addr_oe_follow_a: assert property (!bus_grant_out == (addr_lo_oe & addr_mid_oe & addr_hi_oe))
		else $error("address drive does not follow bus ownership");
	pins_released_a: assert property (bus_grant_out |-> !(data_oe | read_write_oe | addr_lo_oe))
		else $error("shared pins driven while granted");
	grant_cause_a: assert property ($rose(bus_grant_out) |-> $past(bus_takeover_request, 2))
		else $error("grant without takeover request");
	grant_drop_a: assert property ($fell(bus_grant_out) |-> !$past(bus_takeover_request, 2))
		else $error("grant dropped while takeover held");
	regain_req_a: assert property (bus_grant_out |-> bus_regain_request_dma_transfer_strobe == req_valid)
		else $error("regain request does not follow pending work");
	dma_strobe_a: assert property (dma_strobe_on |-> dma_ack_ch_n != 4'hf ##1 (bus_grant_out || bus_regain_request_dma_transfer_strobe))
		else $error("dma strobe without ack or longer than one cycle");
	column_mux_a: assert property (!bus_grant_out && column_strobe_lane_n != 4'hf |-> addr_mux_column_select)
		else $error("column strobe with row address selected");
	one_select_a: assert property ($onehot0(~{sram_select_bank_n, bank_select_or_row_strobe_n}))
		else $error("more than one bank selected");
	dram_rw_a: assert property (!bus_grant_out && !dram_read_enable_n |-> read_write_out && dram_write_strobe_n)
		else $error("dram read enable on a write");
	irq_pulse_a: assert property (irq_low_high |-> ##[1:5] critical_irq ##1 !critical_irq)
		else $error("critical interrupt not raised once");
	err_set_a: assert property (machine_check_detect |=> sys_error)
		else $error("system error not raised");
	err_hold_a: assert property (sys_error && !syndrome_clear |=> sys_error)
		else $error("system error dropped before clear");
endmodule : ebip_top_chk

/* File: ebip_top_test.sv */
// ebip_top_test.sv: self-checking bench for the external bus pin interface
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module ebip_top_test;
	import ebip_pkg::*;
	logic core_clk = 1'h0, sys_rst = 1'h1, req_valid = 1'h0, rsp_ready = 1'h0, bus_takeover_request = 1'h0;
	logic machine_check_detect = 1'h0, syndrome_clear = 1'h0, critical_irq_in_n = 1'h1, xrw = 1'h0, sram_drv = 1'h1;
	logic stall = 1'h0, fault_en = 1'h0, boot_fixed = 1'h0, boot_val = 1'h0, tc_seen = 1'h0;
	logic bus_fault, fault_seen = 1'h0;
	logic req_ready, rsp_valid, sys_error, critical_irq, boot_width_valid, addr_lo_oe, addr_mid_oe, addr_hi_oe;
	logic data_oe, read_write_out, read_write_oe, addr_mux_column_select, bus_regain_request_dma_transfer_strobe;
	logic dram_read_enable_n, dram_write_strobe_n, sram_read_enable_n_out, sram_read_enable_n_oe, bus_grant_out;
	logic read_write_in, boot_width_select, bus_fault_in_n, sram_read_enable_n_in;
	logic [0:3] dma_req_ch_n = 4'hf, eot_drv = 4'hf, end_or_count_role_bit = 4'h4;
	logic [0:3] dma_req, dma_end_request, column_strobe_lane_n, sram_select_bank_n, dma_ack_ch_n;
	logic [0:3] dma_end_or_count_ch_n_in, dma_end_or_count_ch_n_out, dma_end_or_count_ch_n_oe;
	logic [4:7] bank_select_or_row_strobe_n;
	logic [3:0] bank_is_dram = 4'h1;
	logic [5:0] addr_lo_in, addr_lo_out, xlo = 6'h0;
	logic [9:0] addr_mid_out;
	logic [7:0] addr_hi_in, addr_hi_out, xhi = 8'h0;
	logic [0:31] data_in, data_out;
	ebip_req_t req = '0;
	ebip_rsp_t rsp, exp_rsp, exp_q[$];
	ebip_boot_t boot_width;
	ebip_ext_t ext_master;
	int compares = 0, mismatches = 0, n;
	integer seed = 32'h99874fdd;
	always #25 core_clk = ~core_clk;
	assign boot_width_select = boot_fixed ? boot_val : ~sys_rst;
	assign addr_lo_in = addr_lo_oe ? addr_lo_out : xlo;
	assign addr_hi_in = addr_hi_oe ? addr_hi_out : xhi;
	assign read_write_in = read_write_oe ? read_write_out : xrw;
	assign dma_end_or_count_ch_n_in = (dma_end_or_count_ch_n_oe & dma_end_or_count_ch_n_out) |
		(~dma_end_or_count_ch_n_oe & eot_drv);
	assign sram_read_enable_n_in = sram_read_enable_n_oe ? sram_read_enable_n_out : sram_drv;
	ebip_top dut (.core_clk, .sys_rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_ready, .rsp, .bus_fault,
		.bank_is_dram, .end_or_count_role_bit, .dma_req, .dma_end_request, .machine_check_detect, .syndrome_clear,
		.sys_error, .critical_irq, .boot_width, .boot_width_valid, .ext_master, .ext_page_cross(), .addr_lo_in,
		.addr_lo_out, .addr_lo_oe, .addr_mid_out, .addr_mid_oe, .addr_hi_in, .addr_hi_out, .addr_hi_oe, .data_in,
		.data_out, .data_oe, .read_write_in, .read_write_out, .read_write_oe, .addr_mux_column_select,
		.boot_width_select, .bus_fault_in_n, .bus_regain_request_dma_transfer_strobe, .column_strobe_lane_n,
		.critical_irq_in_n, .sram_select_bank_n, .bank_select_or_row_strobe_n, .dma_ack_ch_n, .dma_req_ch_n,
		.dram_read_enable_n, .dram_write_strobe_n, .dma_end_or_count_ch_n_in, .dma_end_or_count_ch_n_out,
		.dma_end_or_count_ch_n_oe, .sram_read_enable_n_in, .sram_read_enable_n_out, .sram_read_enable_n_oe,
		.bus_grant_out, .bus_takeover_request);
	ebip_mem_model mem (.core_clk, .sram_select_bank_n, .bank_select_or_row_strobe_n, .column_strobe_lane_n,
		.addr_lo_out, .addr_mid_out, .addr_hi_out, .data_out, .read_write_out, .fault_en, .data_in, .bus_fault_in_n);
	always @(posedge core_clk) begin
		#1 rsp_ready = !stall && (($random(seed) & 1) != 0);
	end
	always @(posedge core_clk) begin
		if (!bus_grant_out && !bus_regain_request_dma_transfer_strobe && !dma_end_or_count_ch_n_out[1])
			tc_seen <= dma_end_or_count_ch_n_oe[1];
		if (!sys_rst && bus_fault)
			fault_seen <= 1'h1;
		if (!sys_rst && rsp_valid && rsp_ready) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("[ERR] rsp exp none got %h", rsp);
			end else begin
				exp_rsp = exp_q.pop_front();
				`CHK("rsp", exp_rsp, rsp)
			end
		end
	end
	task final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	task timeout(input string what);
		mismatches++;
		$display("[ERR] %s exp done got timeout", what);
		final_report();
	endtask : timeout
	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : step
	task automatic access(input logic wr, input logic [2:0] bank, input logic dm, input logic [0:3] be);
		int k;
		req = '{addr: 24'($random(seed)), wdata: 32'($random(seed)), be: be, write: wr, bank: bank,
			waits: 4'h2 + 4'($random(seed) & 1), dma: dm, dma_ch: 2'h1, last: dm};
		req_valid = 1'h1;
		k = 0;
		do begin @(posedge core_clk); k++; end while (req_ready !== 1'h1 && k < 300);
		if (req_ready !== 1'h1) timeout("req_ready");
		if (!wr) exp_q.push_back('{rdata: {8'ha5, req.addr}, fault: fault_en});
		step(0);
		req_valid = 1'h0;
		k = 0;
		while (wr && req_ready !== 1'h1 && k < 50) begin step(1); k++; end
		if (wr && req_ready !== 1'h1) timeout("write");
		if (!wr) step(1);
	endtask : access
	task automatic drain;
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 500) begin step(1); k++; end
		if (exp_q.size() != 0) timeout("rsp");
		step(2);
	endtask : drain
	task automatic do_reset(input ebip_boot_t bw);
		int k;
		sys_rst = 1'h1;
		step(8);
		sys_rst = 1'h0;
		step(3);
		k = 0;
		while (boot_width_valid !== 1'h1 && k < 20) begin step(1); k++; end
		`CHK("boot", bw, boot_width)
	endtask : do_reset
	initial begin
		do_reset(boot_16);
		for (int ch = 0; ch < 4; ch++) begin
			dma_req_ch_n = ~(4'h8 >> ch);
			step(4);
			`CHK("dma_req", 4'h8 >> ch, dma_req)
		end
		dma_req_ch_n = 4'hf;
		eot_drv = 4'h7;
		step(4);
		`CHK("eot_in", 4'h8, dma_end_request)
		eot_drv = 4'hf;
		for (int i = 0; i < 8; i++)
			access(1'h0, 3'(i), 1'h0, 4'hf);
		drain();
		fault_en = 1'h1;
		access(1'h0, 3'h5, 1'h0, 4'hf);
		drain();
		`CHK("fault_pulse", 1'h1, fault_seen)
		fault_en = 1'h0;
		access(1'h1, 3'h4, 1'h0, 4'ha);
		`CHK("wr_word", req.wdata, mem.wr_word)
		`CHK("lanes", 4'h5, mem.lanes_seen)
		access(1'h1, 3'h1, 1'h1, 4'hf);
		`CHK("tc", 1'h1, tc_seen)
		stall = 1'h1;
		access(1'h0, 3'h0, 1'h0, 4'hf);
		access(1'h0, 3'h4, 1'h0, 4'hf);
		step(10);
		`CHK("full", 1'h0, req_ready)
		stall = 1'h0;
		drain();
		xlo = 6'h2a;
		xhi = 8'h5c;
		xrw = 1'h1;
		eot_drv = 4'he;
		dma_req_ch_n = 4'he;
		bus_takeover_request = 1'h1;
		n = 0;
		while (bus_grant_out !== 1'h1 && n < 20) begin step(1); n++; end
		step(4);
		`CHK("ext", (ebip_ext_t'{6'h2a, 8'h5c, 2'h1, 1'h1, 1'h1}), ext_master)
		`CHK("ext_master_data_ack", 1'h0, dma_ack_ch_n[3])
		fork
			access(1'h0, 3'h2, 1'h0, 4'hf);
			begin
				step(6);
				bus_takeover_request = 1'h0;
				dma_req_ch_n = 4'hf;
				eot_drv = 4'hf;
			end
		join
		drain();
		critical_irq_in_n = 1'h0;
		step(1);
		critical_irq_in_n = 1'h1;
		n = 0;
		while (critical_irq !== 1'h1 && n < 8) begin step(1); n++; end
		`CHK("irq", 1'h1, critical_irq)
		machine_check_detect = 1'h1;
		step(1);
		machine_check_detect = 1'h0;
		step(3);
		`CHK("err_hold", 1'h1, sys_error)
		syndrome_clear = 1'h1;
		step(1);
		syndrome_clear = 1'h0;
		step(1);
		`CHK("err_clr", 1'h0, sys_error)
		boot_fixed = 1'h1;
		do_reset(boot_8);
		boot_val = 1'h1;
		do_reset(boot_32);
		final_report();
	end
endmodule : ebip_top_test
bind ebip_top ebip_top_chk chk (.core_clk, .sys_rst, .req_valid, .bus_grant_out, .bus_takeover_request,
	.addr_lo_oe, .addr_mid_oe, .addr_hi_oe, .data_oe, .read_write_oe, .read_write_out,
	.bus_regain_request_dma_transfer_strobe, .addr_mux_column_select, .column_strobe_lane_n, .sram_select_bank_n,
	.bank_select_or_row_strobe_n, .dma_ack_ch_n, .dram_read_enable_n, .dram_write_strobe_n, .critical_irq_in_n,
	.critical_irq, .machine_check_detect, .syndrome_clear, .sys_error);
